// ===== shared/lcdw_cfg.svh
// Offsets, field codes, reset values and timing constants of the segment LCD waveform block.
// Assumes inclusion by bare name from the design modules.
`ifndef LCDW_CFG_SVH
`define LCDW_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LCDW_OFF_CTRL 8'h00
`define LCDW_OFF_CLK 8'h04
`define LCDW_OFF_SEG_FIRST 8'h08
`define LCDW_OFF_SEG_LAST 8'h3C
`define LCDW_IDX_CTRL 4'h0
`define LCDW_IDX_CLK 4'h1
`define LCDW_IDX_SEG_FIRST 4'h2
`define LCDW_SEG_REGS 14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCDW_CTRL_RESET 8'h00
`define LCDW_CLK_RESET 8'h00
`define LCDW_SEG_RESET 8'h00

// ----------------------------------------
// Codes
// ----------------------------------------
`define LCDW_DUTY_STATIC 2'h0
`define LCDW_DUTY_THIRD 2'h1
`define LCDW_DUTY_QUARTER 2'h2
`define LCDW_BURST_32 2'h0
`define LCDW_BURST_64 2'h1
`define LCDW_LVL_VLCD 2'h0
`define LCDW_LVL_V1 2'h1
`define LCDW_LVL_V2 2'h2
`define LCDW_LVL_V3 2'h3

// ----------------------------------------
// Half base periods in reference clock edges (divide ratio / 2)
// ----------------------------------------
`define LCDW_HALF_DIV128 16'h0040
`define LCDW_HALF_DIV256 16'h0080
`define LCDW_HALF_DIV512 16'h0100
`define LCDW_HALF_DIV1024 16'h0200
`define LCDW_HALF_DIV16384 16'h2000
`define LCDW_HALF_DIV32768 16'h4000
`define LCDW_HALF_DIV65536 16'h8000

`endif

// ===== shared/lcdw_pkg.sv
// Types shared by the segment LCD waveform block.
// Assumes lcdw_cfg.svh supplies the numeric constants.
package lcdw_pkg;

  // ----------------------------------------
  // Register layouts
  // ----------------------------------------
  typedef struct packed {
    logic drive_enable;
    logic quick_charge_sel;
    logic reduced_current_sel;
    logic rsvd;
    logic [3:0] contrast_level;
  } lcdw_ctrl_t;

  typedef struct packed {
    logic rsvd;
    logic [1:0] charge_burst_len;
    logic [1:0] duty;
    logic [2:0] base_clock_div_sel;
  } lcdw_clk_t;

  // ----------------------------------------
  // Panel line levels, two bits each
  // ----------------------------------------
  typedef struct packed {
    logic [25:0][1:0] fp;
    logic [1:0] shared_line;
    logic [2:0][1:0] bp;
  } lcdw_pins_t;

  typedef struct packed {
    logic connect;
    logic low_res;
    logic [3:0] contrast_level;
  } lcdw_ladder_t;

endpackage

// ===== hdl/lcdw_apb.sv
// APB slave front end: one wait state, registered read data, error on unmapped addresses.
// Assumes an APB master on CLK and a read word supplied by the register file.
`timescale 1ns/1ps
`include "lcdw_cfg.svh"
module lcdw_apb #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [7:0] rd_word,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_en,
  output logic [3:0] reg_idx
);
  logic rdy_r;
  logic rdy_nxt;
  logic [7:0] rdat_r;
  logic [7:0] rdat_nxt;
  logic addr_ok;

  assign reg_idx = paddr[5:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:6] == '0);

  // ----------------------------------------
  // Access phase sequencing
  // ----------------------------------------
  always_comb
  begin
    rdy_nxt = psel && penable && !rdy_r;
    rdat_nxt = rdat_r;
    if (psel && penable && !rdy_r)
    begin
      rdat_nxt = addr_ok ? rd_word : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdy_r <= 1'b0;
      rdat_r <= 8'h00;
    end
    else
    begin
      rdy_r <= rdy_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign pready = rdy_r;
  assign pslverr = rdy_r && !addr_ok;
  assign prdata = {24'h000000, rdat_r};
  assign wr_en = psel && penable && rdy_r && pwrite && addr_ok;
endmodule

// ===== hdl/lcdw_basediv.sv
// Base clock divider: reference clock edge detection, half period ticks and charge bursts.
// Assumes the reference clock is slower than half of CLK and arrives asynchronously.
`timescale 1ns/1ps
`include "lcdw_cfg.svh"
module lcdw_basediv (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ref_clk_pin,
  input wire logic run,
  input wire logic [2:0] div_sel,
  input wire logic [1:0] burst_sel,
  output logic half_tick,
  output logic in_burst
);
  logic sync1_r, sync2_r, prev_r;
  logic [15:0] hcnt_r;
  logic [15:0] hcnt_nxt;
  logic [15:0] half_len;
  logic [15:0] burst_len;
  logic ref_edge;

  // Divide ratio over two; the reserved code falls back to the slowest ratio
  function automatic logic [15:0] half_of(input logic [2:0] sel);
    unique case (sel)
      3'h0: half_of = `LCDW_HALF_DIV128;
      3'h1: half_of = `LCDW_HALF_DIV256;
      3'h2: half_of = `LCDW_HALF_DIV512;
      3'h3: half_of = `LCDW_HALF_DIV1024;
      3'h4: half_of = `LCDW_HALF_DIV16384;
      3'h5: half_of = `LCDW_HALF_DIV32768;
      default: half_of = `LCDW_HALF_DIV65536;
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
      hcnt_r <= 16'h0000;
    end
    else
    begin
      sync1_r <= ref_clk_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      hcnt_r <= hcnt_nxt;
    end
  end

  assign ref_edge = sync2_r && !prev_r;
  assign half_len = half_of(div_sel);
  // Burst is a fraction of the full period: period/32 equals half/16
  assign burst_len = (burst_sel == `LCDW_BURST_32) ? (half_len >> 4) :
                     (burst_sel == `LCDW_BURST_64) ? (half_len >> 5) : (half_len >> 6);

  // >= lets a shortened ratio wrap at once instead of running to overflow
  always_comb
  begin
    hcnt_nxt = hcnt_r;
    half_tick = 1'b0;
    if (!run)
    begin
      hcnt_nxt = 16'h0000;
    end
    else if (ref_edge)
    begin
      if (hcnt_r >= half_len - 16'h0001)
      begin
        hcnt_nxt = 16'h0000;
        half_tick = 1'b1;
      end
      else
      begin
        hcnt_nxt = hcnt_r + 16'h0001;
      end
    end
  end

  assign in_burst = run && (hcnt_r < burst_len);
endmodule

// ===== hdl/lcdw_top.sv
// Segment LCD waveform controller: APB registers, frame sequencing and per-line level codes.
// Assumes analog line drivers and the bias ladder sit outside and follow the level and ladder codes.
//
// How it works
// - Thirty panel lines, eight shared with port C
// - Shared line is common only in quarter duty
// - Lines 19 to 26 need port C share bits
// - Sixteen registers: control, clock, fourteen segment
// - Enable bit drives all lines, reset clears it
// - Ladder resistance follows low-current and charge bits
// - Four-bit contrast code passed to the ladder
// - Fast charge burst each half period, length selectable
// - Duty field: static, third, quarter; reset clears
// - Base divider 128 to 1024 for low codes
// - Base divider 16384 to 65536 for high codes
// - Frame lasts one, three or four base periods
// - Segment waveform depends on duty and data bits
// - Commons output periodic waveform, unused stay idle
// - Data bits switch each segment-common pair
// - Divider runs from oscillator reference clock
// - Each data register but the last serves two segment lines (register 0 one in quarter duty)
// - Disabled: all lines at supply, ladder disconnected
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
`include "lcdw_cfg.svh"
module lcdw_top #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  input wire logic OSC_REF_CLOCK,
  input wire logic PORTC_LOW_SHARE,
  input wire logic PORTC_HIGH_SHARE,
  output lcdw_pkg::lcdw_pins_t PANEL_LEVELS,
  output logic [7:0] PORTC_LCD_OWN,
  output logic SHARED_IS_COMMON,
  output lcdw_pkg::lcdw_ladder_t LADDER
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  lcdw_pkg::lcdw_ctrl_t ctrl_r;
  lcdw_pkg::lcdw_ctrl_t ctrl_nxt;
  lcdw_pkg::lcdw_clk_t clk_r;
  lcdw_pkg::lcdw_clk_t clk_nxt;
  logic [7:0] seg_r [`LCDW_SEG_REGS];
  logic [7:0] seg_nxt [`LCDW_SEG_REGS];
  logic wr_en;
  logic [3:0] reg_idx;
  logic [7:0] rd_word;
  logic half_tick;
  logic in_burst;
  logic run;

  lcdw_apb #(
    .ADDR_W(ADDR_W)
  ) u_apb (
    .clk(CLK),
    .rst_n(RST_N),
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .rd_word(rd_word),
    .pready(PREADY),
    .pslverr(PSLVERR),
    .prdata(PRDATA),
    .wr_en(wr_en),
    .reg_idx(reg_idx)
  );

  // Registers are eight bits wide, so only byte lane 0 matters
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    clk_nxt = clk_r;
    for (int i = 0; i < `LCDW_SEG_REGS; i++)
    begin
      seg_nxt[i] = seg_r[i];
    end
    if (wr_en && PSTRB[0])
    begin
      if (reg_idx == `LCDW_IDX_CTRL)
      begin
        ctrl_nxt = PWDATA[7:0];
        ctrl_nxt.rsvd = 1'b0;
      end
      else if (reg_idx == `LCDW_IDX_CLK)
      begin
        clk_nxt = PWDATA[7:0];
        clk_nxt.rsvd = 1'b0;
      end
      else
      begin
        seg_nxt[reg_idx - `LCDW_IDX_SEG_FIRST] = PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ctrl_r <= `LCDW_CTRL_RESET;
      clk_r <= `LCDW_CLK_RESET;
      for (int i = 0; i < `LCDW_SEG_REGS; i++)
      begin
        seg_r[i] <= `LCDW_SEG_RESET;
      end
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      clk_r <= clk_nxt;
      for (int i = 0; i < `LCDW_SEG_REGS; i++)
      begin
        seg_r[i] <= seg_nxt[i];
      end
    end
  end

  // Sixteen words map the whole decoded space
  always_comb
  begin
    if (reg_idx == `LCDW_IDX_CTRL)
    begin
      rd_word = ctrl_r;
    end
    else if (reg_idx == `LCDW_IDX_CLK)
    begin
      rd_word = clk_r;
    end
    else
    begin
      rd_word = seg_r[reg_idx - `LCDW_IDX_SEG_FIRST];
    end
  end

  // ----------------------------------------
  // Base clock
  // ----------------------------------------
  assign run = ctrl_r.drive_enable;

  lcdw_basediv u_div (
    .clk(CLK),
    .rst_n(RST_N),
    .ref_clk_pin(OSC_REF_CLOCK),
    .run(run),
    .div_sel(clk_r.base_clock_div_sel),
    .burst_sel(clk_r.charge_burst_len),
    .half_tick(half_tick),
    .in_burst(in_burst)
  );

  // ----------------------------------------
  // Frame sequencing: slot is the active common, half the waveform phase
  // ----------------------------------------
  logic half_r;
  logic half_nxt;
  logic [1:0] slot_r;
  logic [1:0] slot_nxt;
  logic [1:0] last_slot;
  logic quarter;
  logic is_static;

  // The unused duty code behaves as static
  assign quarter = (clk_r.duty == `LCDW_DUTY_QUARTER);
  assign is_static = !quarter && (clk_r.duty != `LCDW_DUTY_THIRD);
  assign last_slot = quarter ? 2'h3 : (is_static ? 2'h0 : 2'h2);

  always_comb
  begin
    half_nxt = half_r;
    slot_nxt = slot_r;
    if (!run)
    begin
      half_nxt = 1'b0;
      slot_nxt = 2'h0;
    end
    else if (half_tick)
    begin
      half_nxt = !half_r;
      if (half_r)
      begin
        slot_nxt = (slot_r >= last_slot) ? 2'h0 : slot_r + 2'h1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      half_r <= 1'b0;
      slot_r <= 2'h0;
    end
    else
    begin
      half_r <= half_nxt;
      slot_r <= slot_nxt;
    end
  end

  // ----------------------------------------
  // Level coding, third bias
  // ----------------------------------------
  function automatic logic [1:0] com_level(input logic used, input logic active, input logic ph,
                                           input logic stat);
    if (!used)
    begin
      com_level = `LCDW_LVL_VLCD;
    end
    else if (active || stat)
    begin
      com_level = ph ? `LCDW_LVL_V3 : `LCDW_LVL_VLCD;
    end
    else
    begin
      com_level = ph ? `LCDW_LVL_V1 : `LCDW_LVL_V2;
    end
  endfunction

  // A lit segment sits opposite its active common; static uses only the two outer levels
  function automatic logic [1:0] seg_level(input logic on, input logic ph, input logic stat);
    if (on)
    begin
      seg_level = ph ? `LCDW_LVL_VLCD : `LCDW_LVL_V3;
    end
    else if (stat)
    begin
      seg_level = ph ? `LCDW_LVL_V3 : `LCDW_LVL_VLCD;
    end
    else
    begin
      seg_level = ph ? `LCDW_LVL_V2 : `LCDW_LVL_V1;
    end
  endfunction

  // Frontplane n reads nibble n%2 of data register n/2, bit = active common
  function automatic logic seg_bit(input logic [7:0] data, input logic odd, input logic [1:0] slot);
    seg_bit = data[{odd, slot}];
  endfunction

  // ----------------------------------------
  // Line outputs
  // ----------------------------------------
  lcdw_pkg::lcdw_pins_t pins_r;
  lcdw_pkg::lcdw_pins_t pins_nxt;
  lcdw_pkg::lcdw_ladder_t ladder_r;
  lcdw_pkg::lcdw_ladder_t ladder_nxt;
  logic [7:0] own_r;
  logic [7:0] own_nxt;
  logic share_com_r;
  logic share_com_nxt;

  always_comb
  begin
    pins_nxt = '0;
    for (int b = 0; b < 3; b++)
    begin
      pins_nxt.bp[b] = com_level(b == 0 || (!is_static), slot_r == b[1:0], half_r, is_static);
    end
    if (quarter)
    begin
      pins_nxt.shared_line = com_level(1'b1, slot_r == 2'h3, half_r, 1'b0);
    end
    else
    begin
      pins_nxt.shared_line = seg_level(seg_bit(seg_r[0], 1'b0, slot_r), half_r, is_static);
    end
    for (int f = 1; f < 27; f++)
    begin
      pins_nxt.fp[f-1] = seg_level(seg_bit(seg_r[f/2], f[0], slot_r), half_r, is_static);
    end
    if (!run)
    begin
      pins_nxt = '0;
    end
  end

  always_comb
  begin
    ladder_nxt.connect = run;
    // Low resistance unless low current is chosen, or briefly at each edge in fast charge
    ladder_nxt.low_res = run && (!ctrl_r.reduced_current_sel || (ctrl_r.quick_charge_sel && in_burst));
    ladder_nxt.contrast_level = ctrl_r.contrast_level;
    own_nxt = {{4{PORTC_HIGH_SHARE}}, {4{PORTC_LOW_SHARE}}};
    share_com_nxt = quarter;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      pins_r <= '0;
      ladder_r <= '0;
      own_r <= 8'h00;
      share_com_r <= 1'b0;
    end
    else
    begin
      pins_r <= pins_nxt;
      ladder_r <= ladder_nxt;
      own_r <= own_nxt;
      share_com_r <= share_com_nxt;
    end
  end

  assign PANEL_LEVELS = pins_r;
  assign LADDER = ladder_r;
  assign PORTC_LCD_OWN = own_r;
  assign SHARED_IS_COMMON = share_com_r;
endmodule

// ===== testbench/lcdw_top_asserts.sv
// Port-level checker for the segment LCD waveform controller.
// Assumes lcdw_pkg is compiled first; it is bound to lcdw_top below.
`timescale 1ns/1ps
module lcdw_top_asserts #(
  parameter int ADDR_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic PORTC_LOW_SHARE,
  input wire logic PORTC_HIGH_SHARE,
  input wire lcdw_pkg::lcdw_pins_t PANEL_LEVELS,
  input wire logic [7:0] PORTC_LCD_OWN,
  input wire logic SHARED_IS_COMMON,
  input wire lcdw_pkg::lcdw_ladder_t LADDER
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  a_ready_one_wait: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("unaligned access not refused");
  a_rdata_upper: assert property (PREADY |-> PRDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  // ----------------------------------------
  // Panel side
  // ----------------------------------------
  a_disabled_idle: assert property (!LADDER.connect && !$past(LADDER.connect) |-> PANEL_LEVELS == '0)
    else $error("lines not at supply while disabled");
  a_ladder_off: assert property (!LADDER.connect |-> !LADDER.low_res)
    else $error("ladder switched while disconnected");
  a_portc_own: assert property ($past(RST_N) |->
    PORTC_LCD_OWN == {{4{$past(PORTC_HIGH_SHARE)}}, {4{$past(PORTC_LOW_SHARE)}}})
    else $error("port C ownership wrong");
  // Outside static duty common and segment levels never share parity, so a shared line acting as common differs from fp0 in bit 0
  a_shared_role: assert property (SHARED_IS_COMMON && $past(SHARED_IS_COMMON, 2) && LADDER.connect
    && $past(LADDER.connect, 2) |-> PANEL_LEVELS.shared_line[0] != PANEL_LEVELS.fp[0][0])
    else $error("shared line not a common in quarter duty");
  c_write_done: cover property (PSEL && PENABLE && PREADY && PWRITE);
  c_error: cover property (PREADY && PSLVERR);
  c_quarter: cover property ($rose(SHARED_IS_COMMON));
  c_burst: cover property (LADDER.connect && $rose(LADDER.low_res));
endmodule
bind lcdw_top lcdw_top_asserts #(.ADDR_W(ADDR_W)) u_asserts (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
  .PORTC_LOW_SHARE(PORTC_LOW_SHARE), .PORTC_HIGH_SHARE(PORTC_HIGH_SHARE), .PANEL_LEVELS(PANEL_LEVELS),
  .PORTC_LCD_OWN(PORTC_LCD_OWN), .SHARED_IS_COMMON(SHARED_IS_COMMON), .LADDER(LADDER));

// ===== testbench/lcdw_panel.sv
// Passive glass model: notes which commons reach a full swing against segment line 1.
// Assumes level codes 0 (supply) and 3 (bias bottom) are the two extremes.
`timescale 1ns/1ps
module lcdw_panel (
  input wire logic clk,
  input wire logic clr,
  input wire lcdw_pkg::lcdw_pins_t levels,
  output logic [3:0] lit
);
  logic [3:0][1:0] com;
  assign com = {levels.shared_line, levels.bp};
  // Only a full supply-to-bottom difference darkens a segment
  function automatic logic full(input logic [1:0] a, input logic [1:0] b);
    return (a ^ b) == 2'h3 && a[0] == a[1];
  endfunction
  always @(posedge clk)
  begin
    for (int k = 0; k < 4; k++)
    begin
      lit[k] <= clr ? 1'b0 : lit[k] | full(com[k], levels.fp[0]);
    end
  end
endmodule

// ===== testbench/lcdw_top_test.sv
// Self-checking bench for lcdw_top: APB register access, ladder, divider and duty waveforms.
// Assumes the design, package, checker and glass model are compiled before it.
`timescale 1ns/1ps
module lcdw_top_test;
  logic CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic OSC_REF_CLOCK = 0, PORTC_LOW_SHARE = 0, PORTC_HIGH_SHARE = 0, lit_clr = 0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000;
  logic [3:0] PSTRB = 4'hF;
  logic PREADY, PSLVERR, SHARED_IS_COMMON;
  logic [31:0] PRDATA;
  logic [7:0] PORTC_LCD_OWN;
  logic [3:0] lit;
  logic [1:0] ref_div = 2'h0;
  lcdw_pkg::lcdw_pins_t PANEL_LEVELS;
  lcdw_pkg::lcdw_ladder_t LADDER;
  int err_count = 0, checks = 0;
  always #4 CLK = ~CLK;
  // Reference at a quarter of CLK keeps half periods at twice the divide ratio
  always @(posedge CLK)
  begin
    ref_div <= ref_div + 2'h1;
    OSC_REF_CLOCK <= ref_div[1];
  end
  lcdw_top dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PSTRB(PSTRB), .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA),
    .OSC_REF_CLOCK(OSC_REF_CLOCK), .PORTC_LOW_SHARE(PORTC_LOW_SHARE), .PORTC_HIGH_SHARE(PORTC_HIGH_SHARE),
    .PANEL_LEVELS(PANEL_LEVELS), .PORTC_LCD_OWN(PORTC_LCD_OWN), .SHARED_IS_COMMON(SHARED_IS_COMMON),
    .LADDER(LADDER));
  lcdw_panel u_panel (.clk(CLK), .clr(lit_clr), .levels(PANEL_LEVELS), .lit(lit));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("counts: %0d mismatches in %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp, input int tol);
    chk(64'(got > exp - tol && got < exp + tol), 64'h1);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n++;
    end
    if (n == 20)
    begin
      err_count++;
      $display("mismatch at %0t: no ready from slave", $time);
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h000000, d}, r, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, exp);
    chk(e, exp_err);
  endtask
  task automatic wait_change(output int n);
    logic [1:0] p;
    n = 0;
    p = PANEL_LEVELS.bp[0];
    while (PANEL_LEVELS.bp[0] === p && n < 40000)
    begin
      @(posedge CLK);
      n++;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd_chk(8'h00, 8'h00, 1'b0);
    rd_chk(8'h04, 8'h00, 1'b0);
    rd_chk(8'h08, 8'h00, 1'b0);
    rd_chk(8'h02, 8'h00, 1'b1);
    rd_chk(8'h40, 8'h00, 1'b1);
    wr(8'h00, 8'hFF);
    rd_chk(8'h00, 8'hEF, 1'b0);
    wr(8'h04, 8'hFF);
    rd_chk(8'h04, 8'h7F, 1'b0);
    wr(8'h3C, 8'hA5);
    rd_chk(8'h3C, 8'hA5, 1'b0);
    // A write without lane 0 strobe must leave the register alone
    PSTRB <= 4'h0;
    wr(8'h3C, 8'h11);
    PSTRB <= 4'hF;
    rd_chk(8'h3C, 8'hA5, 1'b0);
    wr(8'h00, 8'h00);
  endtask
  task automatic t_idle;
    PORTC_LOW_SHARE <= 1'b1;
    repeat (4) @(posedge CLK);
    chk(PANEL_LEVELS, 64'h0);
    chk(LADDER, 64'h0);
    chk(PORTC_LCD_OWN, 8'h0F);
    PORTC_LOW_SHARE <= 1'b0;
    PORTC_HIGH_SHARE <= 1'b1;
    repeat (3) @(posedge CLK);
    chk(PORTC_LCD_OWN, 8'hF0);
  endtask
  task automatic t_ladder;
    logic [7:0] cv [5] = '{8'hE0, 8'hEA, 8'hEF, 8'hA5, 8'h83};
    logic [7:0] kv [5] = '{8'h00, 8'h20, 8'h40, 8'h00, 8'h00};
    int ev [5] = '{64, 32, 16, 0, 1024};
    int n;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h04, kv[i]);
      wr(8'h00, cv[i]);
      repeat (8) @(posedge CLK);
      n = 0;
      repeat (1024)
      begin
        @(posedge CLK);
        if (LADDER.low_res === 1'b1)
          n++;
      end
      chk_near(n, ev[i], ev[i] / 4 + 4);
      chk(LADDER.contrast_level, cv[i][3:0]);
      chk(LADDER.connect, 1'b1);
    end
  endtask
  task automatic t_divider;
    int n;
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h80);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h04, 8'(c));
      repeat (3) wait_change(n);
      chk_near(n, 256 << c, 2);
    end
    // Restart from a cleared counter so one half period of a high ratio is measured alone
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h04);
    wr(8'h00, 8'h80);
    wait_change(n);
    chk_near(n, 32768, 8);
  endtask
  task automatic t_duty;
    logic [7:0] dv [3] = '{8'h10, 8'h08, 8'h00};
    logic [7:0] sv [3] = '{8'h50, 8'h30, 8'h00};
    logic [3:0] lv [3] = '{4'h5, 4'h3, 4'h6};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h04, dv[i]);
      wr(8'h08, sv[i]);
      repeat (16) @(posedge CLK);
      lit_clr <= 1'b1;
      @(posedge CLK);
      lit_clr <= 1'b0;
      repeat (2400) @(posedge CLK);
      chk(lit, lv[i]);
      chk(SHARED_IS_COMMON, i == 0);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_regs();
    t_idle();
    t_ladder();
    t_divider();
    t_duty();
    finish_test();
  end
  initial
  begin
    repeat (90000) @(posedge CLK);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
